// >>> hw/rarp_dev.sv
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - deliver resolution-sized angle plus update strobe
// - high byte bits 1-8 under high enable
// - low byte bits 9-n under low enable
// - unused low bits read zero
// - angle is natural binary, msb 180 degrees
// - data within 150 ns, release within 100
// - strobe pulse 0.4 to 1.0 us
// - data changes two clocks after strobe fall
// - counter moves 50 ns after strobe begins
// - hold low freezes latch within 0.5 us
// - gate low captures, high follows counter
// - transparent when strobe low, locked when high
// - strobe after hold keeps latch locked
// - hold during strobe locks after pulse
// - hold never disturbs tracking counter
// - host holds, waits 0.5 us, reads, releases
// - hold high at least 1 us reloads
// - byte-wise read timing by host
// - word read timing by host
// - select 00/01/10/11 gives 10/12/14/16 bits
// - resolution sampled at strobe falling edge
module rarp_dev
   import rarp_pkg::*;
#(
   parameter int UPDATE_CYCLES = rarp_pkg::UPDATE_CYC
) (
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // tracking side
   input  wire logic                   track_step,
   input  wire logic                   track_up,
   // link
   rarp_if.dev                         lnk
);
   import rarp_pkg::*;
   // ****************************************
   // tracking counter and strobe
   // ****************************************
   logic [ANGLE_W-1:0] counter;
   logic [CNT_W-1:0]   tick;
   logic [CNT_W-1:0]   str_cnt;
   logic               strobe;
   logic               pending;
   logic               pend_up;
   rarp_res_t          res;
   wire logic [ANGLE_W-1:0] lsb_inc;
   wire logic               str_start;
   wire logic               str_end;
   wire logic               cnt_move;
   // one lsb at the active resolution
   function automatic logic [ANGLE_W-1:0] lsb_of(input rarp_res_t r);
      unique case (r)
         RARP_RES10: return 16'h0040;
         RARP_RES12: return 16'h0010;
         RARP_RES14: return 16'h0004;
         RARP_RES16: return 16'h0001;
      endcase
   endfunction
   assign lsb_inc   = lsb_of(res);
   assign str_start = pending && !strobe;
   assign str_end   = strobe && (str_cnt == CNT_W'(STROBE_CYC - 1));
   assign cnt_move  = strobe && (str_cnt == CNT_W'(CNT_DELAY_CYC));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick    <= '0;
         pending <= 1'b0;
         pend_up <= 1'b0;
      end else begin
         tick <= (tick == CNT_W'(UPDATE_CYCLES - 1)) ? '0 : tick + 1'b1;
         if (track_step && tick == '0) begin
            pending <= 1'b1;
            pend_up <= track_up;
         end else if (str_start) begin
            pending <= 1'b0;
         end
      end
   end

   // strobe and counter run regardless of hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe  <= 1'b0;
         str_cnt <= '0;
         counter <= '0;
         res     <= RARP_RES16;
      end else begin
         if (str_start) begin
            strobe  <= 1'b1;
            str_cnt <= '0;
         end else if (str_end) begin
            strobe  <= 1'b0;
            res     <= rarp_res_t'(lnk.res_sel);
         end else if (strobe) begin
            str_cnt <= str_cnt + 1'b1;
         end
         if (cnt_move) begin
            counter <= pend_up ? counter + lsb_inc : counter - lsb_inc;
         end
      end
   end
   // ****************************************
   // inhibit latch
   // ****************************************
   logic [ANGLE_W-1:0] latch;
   logic               gate;
   logic               hold_seen;
   wire logic          next_gate;
   // hold counts only once no strobe is in flight
   // a hold taken mid pulse locks before the finished update reaches the latch
   assign next_gate = !strobe && !hold_seen;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_seen <= 1'b0;
         gate      <= 1'b1;
         latch     <= '0;
      end else begin
         // hold arriving mid strobe is taken after the pulse
         if (!lnk.hold_request_n && !strobe) begin
            hold_seen <= 1'b1;
         end else if (lnk.hold_request_n) begin
            hold_seen <= 1'b0;
         end
         gate <= next_gate;
         if (gate && next_gate) begin
            latch <= counter;
         end
      end
   end
   // ****************************************
   // byte outputs
   // ****************************************
   wire logic [7:0] low_mask;
   assign low_mask = (res == RARP_RES10) ? LOW_MASK_10 :
                     (res == RARP_RES12) ? LOW_MASK_12 :
                     (res == RARP_RES14) ? LOW_MASK_14 : LOW_MASK_16;

   logic [7:0] hi_q;
   logic [7:0] lo_q;
   logic [7:0] hi_e;
   logic [7:0] lo_e;
   logic       strobe_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_q     <= '0;
         lo_q     <= '0;
         hi_e     <= '0;
         lo_e     <= '0;
         strobe_q <= 1'b0;
      end else begin
         hi_q     <= latch[ANGLE_W-1 -: BYTE_W];
         lo_q     <= latch[BYTE_W-1:0] & low_mask;
         hi_e     <= {BYTE_W{!lnk.high_byte_enable_n}};
         lo_e     <= {BYTE_W{!lnk.low_byte_enable_n}};
         strobe_q <= strobe;
      end
   end
   assign lnk.hi_out        = hi_q;
   assign lnk.lo_out        = lo_q;
   assign lnk.hi_oe         = hi_e;
   assign lnk.lo_oe         = lo_e;
   assign lnk.update_strobe = strobe_q;
endmodule

// >>> hw/rarp_pkg.sv
package rarp_pkg;
   // ****************************************
   // widths and resolution codes
   // ****************************************
   localparam int ANGLE_W = 16;
   localparam int BYTE_W  = 8;
   localparam int CLK_NS  = 4;
   typedef enum logic [1:0] {
      RARP_RES10 = 2'b00,
      RARP_RES12 = 2'b01,
      RARP_RES14 = 2'b10,
      RARP_RES16 = 2'b11
   } rarp_res_t;
   localparam logic [7:0] LOW_MASK_10 = 8'hC0;
   localparam logic [7:0] LOW_MASK_12 = 8'hF0;
   localparam logic [7:0] LOW_MASK_14 = 8'hFC;
   localparam logic [7:0] LOW_MASK_16 = 8'hFF;
   // ****************************************
   // timing, in ns, and derived cycles
   // ****************************************
   // short strobe so a hold landing mid pulse still settles within the hold setup time
   localparam int T_STROBE_NS    = 400;
   localparam int T_CNT_DELAY_NS = 50;
   localparam int T_HOLD_SET_NS  = 500;
   localparam int T_EN_SETUP_NS  = 150;
   localparam int T_EN_WIDTH_NS  = 150;
   localparam int T_RELEASE_NS   = 100;
   localparam int T_HOLD_HIGH_NS = 1000;
   localparam int T_UPDATE_NS    = 2000;
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int STROBE_CYC    = cyc_up(T_STROBE_NS);
   localparam int CNT_DELAY_CYC = cyc_up(T_CNT_DELAY_NS);
   localparam int HOLD_SET_CYC  = cyc_up(T_HOLD_SET_NS);
   localparam int EN_SETUP_CYC  = cyc_up(T_EN_SETUP_NS);
   localparam int EN_WIDTH_CYC  = cyc_up(T_EN_WIDTH_NS);
   localparam int RELEASE_CYC   = cyc_up(T_RELEASE_NS);
   localparam int HOLD_HIGH_CYC = cyc_up(T_HOLD_HIGH_NS);
   localparam int UPDATE_CYC    = cyc_up(T_UPDATE_NS);
   localparam int CNT_W         = 12;
   // ****************************************
   // host apb registers
   // ****************************************
   localparam logic [11:0] REG_CTRL   = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_ANGLE  = 12'h008;
   localparam int CTRL_START = 0;
   localparam int CTRL_WIDE  = 1;
   localparam int CTRL_RES_LO = 2;
endpackage

// >>> hw/rarp_if.sv
`timescale 1ns/1ps
interface rarp_if;
   logic       hold_request_n;
   logic       high_byte_enable_n;
   logic       low_byte_enable_n;
   logic [1:0] res_sel;
   logic       update_strobe;
   logic [7:0] hi_out;
   logic [7:0] hi_oe;
   logic [7:0] lo_out;
   logic [7:0] lo_oe;
   modport dev (
      input  hold_request_n, high_byte_enable_n, low_byte_enable_n, res_sel,
      output update_strobe, hi_out, hi_oe, lo_out, lo_oe
   );
   modport host (
      output hold_request_n, high_byte_enable_n, low_byte_enable_n, res_sel,
      input  update_strobe, hi_out, hi_oe, lo_out, lo_oe
   );
endinterface

// >>> hw/rarp_host.sv
`timescale 1ns/1ps
module rarp_host
   import rarp_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // link
   rarp_if.host             lnk
);
   import rarp_pkg::*;
   // ****************************************
   // read sequencer
   // ****************************************
   typedef enum {H_IDLE, H_SETUP, H_HI, H_LO, H_BOTH, H_REL, H_RECOVER} rarp_hst_t;
   rarp_hst_t   st;
   logic [CNT_W-1:0] cnt;
   logic        wide;
   logic [1:0]  res;
   logic [15:0] angle;
   logic        done;
   logic        hold_n;
   logic        hen_n;
   logic        len_n;
   wire logic   wr;
   wire logic   rd;
   wire logic   start;
   wire logic   cnt_done;
   assign wr       = psel && penable && pwrite && pready;
   assign rd       = psel && !pwrite;
   assign start    = wr && paddr == REG_CTRL && pwdata[CTRL_START] && st == H_IDLE;
   assign cnt_done = cnt == '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st     <= H_IDLE;
         cnt    <= '0;
         wide   <= 1'b0;
         res    <= 2'b11;
         angle  <= '0;
         done   <= 1'b0;
         hold_n <= 1'b1;
         hen_n  <= 1'b1;
         len_n  <= 1'b1;
      end else begin
         if (!cnt_done) cnt <= cnt - 1'b1;
         if (wr && paddr == REG_CTRL) begin
            wide <= pwdata[CTRL_WIDE];
            res  <= pwdata[CTRL_RES_LO +: 2];
         end
         unique case (st)
            H_IDLE: if (start) begin
               hold_n <= 1'b0;
               done   <= 1'b0;
               cnt    <= CNT_W'(HOLD_SET_CYC);
               st     <= H_SETUP;
            end
            H_SETUP: if (cnt_done) begin
               cnt <= CNT_W'(EN_WIDTH_CYC);
               if (wide) begin
                  hen_n <= 1'b0;
                  len_n <= 1'b0;
                  st    <= H_BOTH;
               end else begin
                  hen_n <= 1'b0;
                  st    <= H_HI;
               end
            end
            H_HI: if (cnt_done) begin
               angle[15:8] <= lnk.hi_out;
               hen_n <= 1'b1;
               len_n <= 1'b0;
               cnt   <= CNT_W'(EN_WIDTH_CYC);
               st    <= H_LO;
            end
            H_LO: if (cnt_done) begin
               angle[7:0] <= lnk.lo_out;
               len_n <= 1'b1;
               cnt   <= CNT_W'(RELEASE_CYC);
               st    <= H_REL;
            end
            H_BOTH: if (cnt_done) begin
               angle <= {lnk.hi_out, lnk.lo_out};
               hen_n <= 1'b1;
               len_n <= 1'b1;
               cnt   <= CNT_W'(RELEASE_CYC);
               st    <= H_REL;
            end
            H_REL: if (cnt_done) begin
               hold_n <= 1'b1;
               cnt    <= CNT_W'(HOLD_HIGH_CYC);
               st     <= H_RECOVER;
            end
            H_RECOVER: if (cnt_done) begin
               done <= 1'b1;
               st   <= H_IDLE;
            end
         endcase
      end
   end
   assign lnk.hold_request_n     = hold_n;
   assign lnk.high_byte_enable_n = hen_n;
   assign lnk.low_byte_enable_n  = len_n;
   assign lnk.res_sel            = res;
   // ****************************************
   // apb read path
   // ****************************************
   wire logic [31:0] rmux;
   wire logic        hit;
   assign hit  = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_ANGLE;
   assign rmux = (paddr == REG_CTRL)   ? {28'h000_0000, res, wide, 1'b0} :
                 (paddr == REG_STATUS) ? {30'h0, done, st != H_IDLE} :
                 (paddr == REG_ANGLE)  ? {16'h0, angle} : 32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata  <= (rd && !penable) ? rmux : prdata;
      end
   end
endmodule

// >>> sim/rarp_monitor.sv
`timescale 1ns/1ps
module rarp_monitor
   import rarp_pkg::*;
(
   // clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // link
   input wire logic       hold_request_n,
   input wire logic       high_byte_enable_n,
   input wire logic       low_byte_enable_n,
   input wire logic [1:0] res_sel,
   input wire logic       update_strobe,
   input wire logic [7:0] hi_out,
   input wire logic [7:0] hi_oe,
   input wire logic [7:0] lo_out,
   input wire logic [7:0] lo_oe
);
   logic [11:0] hcnt;
   logic [11:0] scnt;
   logic [11:0] ecnt;
   wire  [7:0]  lmask = 8'hFF << (3'd6 - {res_sel, 1'b0});
   // cycles of hold low, strobe high, high enable low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hcnt <= '0;
         scnt <= '0;
         ecnt <= '0;
      end else begin
         hcnt <= hold_request_n ? 12'h000 : hcnt + 12'h001;
         scnt <= update_strobe ? scnt + 12'h001 : 12'h000;
         ecnt <= high_byte_enable_n ? 12'h000 : ecnt + 12'h001;
      end
   end
   default clocking mcb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence quiet_s;
      !hold_request_n && high_byte_enable_n && low_byte_enable_n;
   endsequence
   hold_first_a: assert property ($fell(hold_request_n) |-> quiet_s [*8])
      else $error("enable too soon after hold");
   oe_hi_a: assert property (hi_oe == ($past(high_byte_enable_n) ? 8'h00 : 8'hFF))
      else $error("high byte drive wrong");
   oe_lo_a: assert property (lo_oe == ($past(low_byte_enable_n) ? 8'h00 : 8'hFF))
      else $error("low byte drive wrong");
   strobe_width_a: assert property ($fell(update_strobe) |-> scnt == STROBE_CYC)
      else $error("strobe width wrong");
   latch_lock_a: assert property (update_strobe && $past(update_strobe)
      |-> $stable(hi_out) && $stable(lo_out)) else $error("data moved in strobe");
   hold_stable_a: assert property (hcnt > 12'h0A0
      |-> $stable(hi_out) && $stable(lo_out)) else $error("data moved in hold");
   unused_low_a: assert property (hcnt > 12'h0A0 |-> (lo_out & ~lmask) == 8'h00)
      else $error("unused low bits set");
   en_setup_a: assert property ($fell(high_byte_enable_n) |-> hcnt >= HOLD_SET_CYC)
      else $error("enable before hold setup");
   en_width_a: assert property ($rose(high_byte_enable_n) |-> ecnt >= EN_WIDTH_CYC)
      else $error("enable too short");
endmodule

// >>> sim/resolver_angle_readout_port_tb.sv
`timescale 1ns/1ps
module resolver_angle_readout_port_tb;
   import rarp_pkg::*;
   localparam int UPD = 200;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_b;
   logic        track_step, track_up, s_prev;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] exp_ang;
   logic [1:0]  res_eff, res;
   int          err_count, cmp_count, seed;
   rarp_if lnk ();
   rarp_dev #(.UPDATE_CYCLES(UPD)) rarp_dev_inst (.pclk(pclk), .presetn(presetn),
      .track_step(track_step), .track_up(track_up), .lnk(lnk.dev));
   rarp_host rarp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lnk(lnk.host));
   rarp_monitor rarp_monitor_inst (.pclk(pclk), .presetn(presetn),
      .hold_request_n(lnk.hold_request_n), .high_byte_enable_n(lnk.high_byte_enable_n),
      .low_byte_enable_n(lnk.low_byte_enable_n), .res_sel(lnk.res_sel),
      .update_strobe(lnk.update_strobe), .hi_out(lnk.hi_out), .hi_oe(lnk.hi_oe),
      .lo_out(lnk.lo_out), .lo_oe(lnk.lo_oe));
   // ****************************************
   // expected angle model
   // ****************************************
   function automatic logic [15:0] mask16(input logic [1:0] r);
      return 16'hFFFF << (4'd6 - {r, 1'b0});
   endfunction
   function automatic logic [15:0] stp(input logic [1:0] r);
      return 16'h0001 << (4'd6 - {r, 1'b0});
   endfunction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exp_ang <= 16'h0000;
         res_eff <= 2'b11;
         s_prev <= 1'b0;
      end else begin
         s_prev <= lnk.update_strobe;
         if (lnk.update_strobe && !s_prev)
            exp_ang <= track_up ? exp_ang + stp(res_eff) : exp_ang - stp(res_eff);
         if (!lnk.update_strobe && s_prev)
            res_eff <= lnk.res_sel;
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic finish_test();
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      cmp_count++;
      if (got !== want) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // look before the edge, so the answer is taken as it stands at that edge
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         finish_test();
      end
      rd = prdata;
      err_b = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_angle(input logic wide, input logic cmp);
      int n;
      n = 0;
      apb(1'b1, REG_CTRL, {28'h0000_000, res, wide, 1'b1});
      do begin
         apb(1'b0, REG_STATUS, 32'h0000_0000);
         n++;
         if (cmp && lnk.hi_oe === 8'hFF)
            chk({24'h00_0000, lnk.hi_out}, {24'h00_0000, exp_ang[15:8]});
      end while (rd[1] !== 1'b1 && n < 400);
      if (n >= 400) begin
         err_count++;
         finish_test();
      end
      apb(1'b0, REG_ANGLE, 32'h0000_0000);
      if (cmp)
         chk(rd, {16'h0000, exp_ang & mask16(res_eff)});
   endtask
   // ****************************************
   // stimulus
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {track_step, track_up, err_b, res} = '0;
      err_count = 0;
      cmp_count = 0;
      seed = $urandom(6729);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk({31'h0, err_b}, 32'h0000_0001);
      // coarse to fine; the first step after reset is one 16 bit lsb, so the counter is aligned only in the 16 bit mode
      for (int r = 0; r < 4; r++) begin
         res = 2'(r);
         apb(1'b1, REG_CTRL, {28'h0000_000, res, 2'b00});
         track_up <= 1'($urandom % 2);
         track_step <= 1'b1;
         repeat (UPD * (2 + $urandom % 6)) @(posedge pclk);
         track_step <= 1'b0;
         repeat (2 * UPD) @(posedge pclk);
         rd_angle(1'($urandom % 2), 1'b1);
         track_step <= 1'b1;
         rd_angle(1'(r), 1'b0);
         track_step <= 1'b0;
         repeat (2 * UPD) @(posedge pclk);
         rd_angle(1'(r + 1), 1'b1);
      end
      finish_test();
   end
endmodule
